// File: csw_defs.svh
// offsets, field positions, reset values and timing counts of the clock manager
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH
`define CSW_OFS_CONTROL      12'h000
`define CSW_OFS_TRIM         12'h004
`define CSW_OFS_UNLOCK       12'h008
`define CSW_OFS_STATUS       12'h00c
`define CSW_OFS_POWER        12'h010
`define CSW_KEY_FIRST        32'h0000_0046
`define CSW_KEY_SECOND       32'h0000_0057
`define CSW_BIT_REQ          0
`define CSW_BIT_LPX_EN       1
`define CSW_BIT_FAIL         3
`define CSW_BIT_LOCK         5
`define CSW_NEW_LO           8
`define CSW_CUR_LO           12
`define CSW_TRIM_W           6
`define CSW_TRIM_RESET       6'h00
`define CSW_SRC_FRC          3'h0
`define CSW_SRC_FRC_PLL      3'h1
`define CSW_SRC_PRI          3'h2
`define CSW_SRC_PRI_PLL      3'h3
`define CSW_SRC_SEC          3'h4
`define CSW_SRC_LOW_POWER_INTERNAL_RC         3'h5
`define CSW_HANDOVER_CYCLES  4'ha
`endif

// File: csw_pkg.sv
// types shared by the clock manager files
package csw_pkg;
  typedef enum logic [2:0] {
    CSW_IDLE     = 3'b000,
    CSW_COMPARE  = 3'b001,
    CSW_START    = 3'b010,
    CSW_HANDOVER = 3'b011,
    CSW_DONE     = 3'b100
  } csw_state_t;

  typedef enum logic [1:0] {
    CSW_RUN   = 2'b00,
    CSW_IDLEM = 2'b01,
    CSW_SLEEP = 2'b10
  } csw_pmode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } csw_apb_req_t;

  typedef struct packed {
    logic       ready_q;
    logic [3:0] cnt_q;
  } csw_hand_t;

  typedef struct packed {
    logic [1:0] s1_q;
    logic [1:0] s2_q;
  } csw_sync_t;
endpackage

// File: csw_sync.sv
// two-flop synchronisers for the oscillator status pins
`timescale 1ns/10ps
module csw_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  csw_pkg::csw_sync_t st_q;
  csw_pkg::csw_sync_t st_d;

  // second stage only reads the first
  always_comb begin
    st_d      = st_q;
    st_d.s1_q = async_in;
    st_d.s2_q = st_q.s1_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2_q;
endmodule

// File: csw_handover.sv
// counts new-source clock ticks before the system clock changes over
`timescale 1ns/10ps
`include "csw_defs.svh"
module csw_handover (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic new_tick,
  output logic      done
);
  csw_pkg::csw_hand_t st_q;
  csw_pkg::csw_hand_t st_d;

  // counting new clock edges
  always_comb begin
    st_d         = st_q;
    st_d.ready_q = 1'b0;
    if (start) begin
      st_d.cnt_q = 4'h0;
    end else if (new_tick && st_q.cnt_q != `CSW_HANDOVER_CYCLES) begin
      st_d.cnt_q = st_q.cnt_q + 4'h1;
      if (st_q.cnt_q + 4'h1 == `CSW_HANDOVER_CYCLES) begin
        st_d.ready_q = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{ready_q: 1'b0, cnt_q: `CSW_HANDOVER_CYCLES};
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.ready_q;
endmodule

// File: csw_clock_manager.sv
// system clock manager: switching, fail-safe monitor, rc trim, sleep and idle
`timescale 1ns/10ps
`include "csw_defs.svh"
module csw_clock_manager (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  switch_cfg_n,
  input  wire logic                  monitor_cfg_n,
  input  wire logic [2:0]            initial_source_config,
  input  wire logic                  wdt_enabled,
  input  wire logic                  osc_ready_pin,
  input  wire logic                  pll_lock_pin,
  input  wire logic                  new_clk_tick,
  input  wire logic                  clock_failed,
  input  wire logic                  pwr_save_req,
  input  wire logic                  pwr_save_sleep,
  input  wire logic                  wake_irq,
  input  wire logic                  wdt_timeout,
  output logic      [5:0]            osc_enable,
  output logic      [2:0]            sys_clk_sel,
  output logic      [`CSW_TRIM_W-1:0] rc_trim_field,
  output logic                       clock_fail_trap,
  output logic                       wdt_clear,
  output logic                       cpu_halt,
  output logic                       periph_clk_en,
  output logic                       handover_start
);
  typedef struct packed {
    csw_pkg::csw_state_t sw;
    csw_pkg::csw_pmode_t pm;
    logic [1:0]          key_q;
    logic [2:0]          new_q;
    logic [2:0]          cur_q;
    logic [2:0]          old_q;
    logic                req_q;
    logic                lpx_q;
    logic                fail_q;
    logic                lock_q;
    logic [5:0]          trim_q;
    logic                pready_q;
    logic                slverr_q;
    logic [31:0]         rdata_q;
    logic [5:0]          oscen_q;
    logic                trap_q;
    logic                wdclr_q;
    logic                hstart_q;
    logic                halt_q;
    logic                pclk_q;
  } csw_state_all_t;

  csw_state_all_t st_q;
  csw_state_all_t st_d;
  logic [1:0]     pins_s;
  logic           hand_done;
  logic           sw_ok;
  logic           setup;
  logic           wr_acc;
  logic [31:0]    ctl_word;
  logic           acc_first;
  logic           win_open;
  logic           mon_on;

  // osc ready and lock come from the analog side
  csw_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({pll_lock_pin, osc_ready_pin}),
    .sync_out (pins_s)
  );

  // ten-tick counter
  csw_handover u_hand (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (st_q.hstart_q),
    .new_tick (new_clk_tick),
    .done     (hand_done)
  );

  // source uses the multiplier
  function automatic logic uses_pll(input logic [2:0] s);
    uses_pll = (s == `CSW_SRC_FRC_PLL) || (s == `CSW_SRC_PRI_PLL);
  endfunction

  // source is a crystal needing start-up timer
  function automatic logic is_xtal(input logic [2:0] s);
    is_xtal = (s == `CSW_SRC_PRI) || (s == `CSW_SRC_PRI_PLL) || (s == `CSW_SRC_SEC);
  endfunction

  // one-hot enable for a source code
  function automatic logic [5:0] src_bit(input logic [2:0] s);
    src_bit = 6'h01 << s;
  endfunction

  // offset hits one of the five registers
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `CSW_OFS_CONTROL) || (a == `CSW_OFS_TRIM) || (a == `CSW_OFS_UNLOCK) ||
             (a == `CSW_OFS_STATUS) || (a == `CSW_OFS_POWER);
  endfunction

  assign sw_ok    = ~switch_cfg_n;
  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign acc_first = psel && penable && !st_q.pready_q;
  // window open for exactly one access after the key pair
  assign win_open = st_q.key_q == 2'b10;
  // monitor runs only when switching is allowed too
  assign mon_on   = sw_ok && !monitor_cfg_n;
  assign ctl_word = {17'h0, st_q.cur_q, 1'b0, st_q.new_q, 2'b00, st_q.lock_q, 1'b0,
                     st_q.fail_q, 1'b0, st_q.lpx_q, st_q.req_q};

  // next-state logic of the whole manager
  always_comb begin
    st_d          = st_q;
    // pulses default low
    st_d.pready_q = 1'b0;
    st_d.slverr_q = 1'b0;
    st_d.trap_q   = 1'b0;
    st_d.wdclr_q  = 1'b0;
    st_d.hstart_q = 1'b0;

    // apb: one wait state, answer on the second access cycle
    if (setup) begin
      if (paddr == `CSW_OFS_CONTROL) begin
        st_d.rdata_q = ctl_word;
      end else if (paddr == `CSW_OFS_TRIM) begin
        st_d.rdata_q = {26'h0, st_q.trim_q};
      end else if (paddr == `CSW_OFS_UNLOCK) begin
        st_d.rdata_q = {30'h0, st_q.key_q};
      end else if (paddr == `CSW_OFS_STATUS) begin
        st_d.rdata_q = {27'h0, st_q.pm, st_q.sw};
      end else if (paddr == `CSW_OFS_POWER) begin
        st_d.rdata_q = {26'h0, st_q.oscen_q};
      end else begin
        st_d.rdata_q = 32'h0;
      end
    end
    // answer and bus error one cycle after the access starts
    if (acc_first) begin
      st_d.pready_q = 1'b1;
      st_d.slverr_q = !mapped(paddr);
    end

    // key sequence; any other completed access closes the window
    if (acc_first) begin
      if (pwrite && paddr == `CSW_OFS_UNLOCK && pwdata == `CSW_KEY_FIRST) begin
        st_d.key_q = 2'b01;
      end else if (pwrite && paddr == `CSW_OFS_UNLOCK && pwdata == `CSW_KEY_SECOND
                   && st_q.key_q == 2'b01) begin
        st_d.key_q = 2'b10;
      end else begin
        st_d.key_q = 2'b00;
      end
    end

    if (wr_acc && !st_q.pready_q && paddr == `CSW_OFS_TRIM) begin
      st_d.trim_q = pwdata[5:0];
    end

    if (wr_acc && !st_q.pready_q && paddr == `CSW_OFS_CONTROL && win_open) begin
      // new code is whole source; submode comes from config only
      st_d.new_q = pwdata[`CSW_NEW_LO +: 3];
      st_d.lpx_q = pwdata[`CSW_BIT_LPX_EN];
      // software may clear the fail flag only
      if (!pwdata[`CSW_BIT_FAIL]) begin
        st_d.fail_q = 1'b0;
      end
      // request only accepted while switching allowed
      if (pwdata[`CSW_BIT_REQ] && sw_ok && st_q.sw == csw_pkg::CSW_IDLE) begin
        st_d.req_q = 1'b1;
        st_d.sw    = csw_pkg::CSW_COMPARE;
      end
    end

    // switch sequence; cpu never halted here
    case (st_q.sw)
      csw_pkg::CSW_IDLE: begin
        // nothing pending
      end
      csw_pkg::CSW_COMPARE: begin
        if (st_q.cur_q == st_q.new_q) begin
          st_d.req_q = 1'b0;
          st_d.sw    = csw_pkg::CSW_IDLE;
        end else begin
          st_d.lock_q  = 1'b0;
          st_d.fail_q  = 1'b0;
          st_d.oscen_q = st_q.oscen_q | src_bit(st_q.new_q);
          st_d.sw      = csw_pkg::CSW_START;
        end
      end
      csw_pkg::CSW_START: begin
        // wait start-up timer and multiplier lock
        if ((!is_xtal(st_q.new_q) || pins_s[0]) && (!uses_pll(st_q.new_q) || pins_s[1])) begin
          st_d.hstart_q = 1'b1;
          st_d.sw       = csw_pkg::CSW_HANDOVER;
        end
      end
      csw_pkg::CSW_HANDOVER: begin
        if (hand_done) begin
          st_d.old_q = st_q.cur_q;
          st_d.cur_q = st_q.new_q;
          st_d.req_q = 1'b0;
          st_d.sw    = csw_pkg::CSW_DONE;
        end
      end
      csw_pkg::CSW_DONE: begin
        // old source off unless needed elsewhere
        st_d.oscen_q = st_q.oscen_q & ~src_bit(st_q.old_q);
        st_d.sw      = csw_pkg::CSW_IDLE;
      end
      default: begin
        // unused codes recover to idle
        st_d.sw = csw_pkg::CSW_IDLE;
      end
    endcase

    st_d.lock_q = uses_pll(st_d.cur_q) ? pins_s[1] : 1'b0;
    // lock cleared while a new switch starts
    if (st_q.sw == csw_pkg::CSW_COMPARE && st_q.cur_q != st_q.new_q) begin
      st_d.lock_q = 1'b0;
    end

    // monitor fallback, only when enabled and not in sleep
    if (mon_on && clock_failed && st_q.pm != csw_pkg::CSW_SLEEP
        && !st_q.fail_q) begin
      st_d.fail_q   = 1'b1;
      st_d.trap_q   = 1'b1;
      st_d.cur_q    = uses_pll(st_q.cur_q) ? `CSW_SRC_FRC_PLL : `CSW_SRC_FRC;
      st_d.oscen_q  = st_q.oscen_q | src_bit(st_d.cur_q);
      st_d.req_q    = 1'b0;
      st_d.sw       = csw_pkg::CSW_IDLE;
    end

    // locked configuration follows the initial source
    if (!sw_ok) begin
      st_d.cur_q = initial_source_config;
      st_d.req_q = 1'b0;
      st_d.sw    = csw_pkg::CSW_IDLE;
    end

    if (pwr_save_req && st_q.pm == csw_pkg::CSW_RUN) begin
      st_d.wdclr_q = 1'b1;
      st_d.pm      = pwr_save_sleep ? csw_pkg::CSW_SLEEP : csw_pkg::CSW_IDLEM;
    end else if ((wake_irq || wdt_timeout) && st_q.pm != csw_pkg::CSW_RUN) begin
      st_d.pm = csw_pkg::CSW_RUN;
    end

    if (st_d.pm == csw_pkg::CSW_SLEEP) begin
      st_d.oscen_q = 6'h00;
      // low-power rc runs for the watchdog
      st_d.oscen_q[`CSW_SRC_LOW_POWER_INTERNAL_RC] = wdt_enabled;
    end else begin
      st_d.oscen_q = st_d.oscen_q | src_bit(st_d.cur_q);
      if (wdt_enabled || mon_on) begin
        st_d.oscen_q[`CSW_SRC_LOW_POWER_INTERNAL_RC] = 1'b1;
      end
    end
    if (st_d.lpx_q && st_d.pm != csw_pkg::CSW_SLEEP) begin
      st_d.oscen_q[`CSW_SRC_SEC] = 1'b1;
    end

    // cpu halted in both modes, peripherals only in sleep
    st_d.halt_q = st_d.pm != csw_pkg::CSW_RUN;
    st_d.pclk_q = st_d.pm != csw_pkg::CSW_SLEEP;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= '0;
      st_q.sw     <= csw_pkg::CSW_IDLE;
      st_q.pm     <= csw_pkg::CSW_RUN;
      st_q.trim_q <= `CSW_TRIM_RESET;
      st_q.pclk_q <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state flops
  assign prdata          = st_q.rdata_q;
  assign pready          = st_q.pready_q;
  assign pslverr         = st_q.slverr_q;
  assign osc_enable      = st_q.oscen_q;
  assign sys_clk_sel     = st_q.cur_q;
  assign rc_trim_field   = st_q.trim_q;
  assign clock_fail_trap = st_q.trap_q;
  assign wdt_clear       = st_q.wdclr_q;
  assign cpu_halt        = st_q.halt_q;
  assign periph_clk_en   = st_q.pclk_q;
  assign handover_start  = st_q.hstart_q;
endmodule

// File: csw_clock_manager_assertions.sv
// concurrent checks on the clock manager ports
`timescale 1ns/10ps
module csw_clock_manager_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       switch_cfg_n,
  input wire logic       monitor_cfg_n,
  input wire logic [2:0] initial_source_config,
  input wire logic       wdt_enabled,
  input wire logic       new_clk_tick,
  input wire logic       clock_failed,
  input wire logic       pwr_save_req,
  input wire logic       wake_irq,
  input wire logic       wdt_timeout,
  input wire logic [5:0] osc_enable,
  input wire logic [2:0] sys_clk_sel,
  input wire logic       clock_fail_trap,
  input wire logic       wdt_clear,
  input wire logic       cpu_halt,
  input wire logic       periph_clk_en,
  input wire logic       handover_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       run_q;
  logic       run_d;
  logic [3:0] tick_q;
  logic [3:0] tick_d;

  // counts new-source ticks once a handover begins
  always_comb begin
    run_d = run_q;
    tick_d = tick_q;
    if (handover_start) begin
      run_d = 1'b1;
      tick_d = 4'h0;
    end else if (run_q && new_clk_tick) begin
      tick_d = tick_q + 4'h1;
      run_d = (tick_q != 4'h9);
    end
  end

  // helper registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      tick_q <= 4'h0;
    end else begin
      run_q <= run_d;
      tick_q <= tick_d;
    end
  end

  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  locked_sel_a: assert property (
    switch_cfg_n && $past(rst_n) |-> sys_clk_sel == $past(initial_source_config))
    else $error("locked source wrong");
  trap_cause_a: assert property (
    clock_fail_trap |-> $past(clock_failed) && !monitor_cfg_n && !switch_cfg_n)
    else $error("trap without cause");
  trap_fallback_a: assert property (
    $rose(clock_fail_trap) |-> ##[0:3] (sys_clk_sel == 3'h0 || sys_clk_sel == 3'h1))
    else $error("no fallback to rc");
  handover_hold_a: assert property (run_q && !clock_fail_trap |-> $stable(sys_clk_sel))
    else $error("source changed early");
  changeover_a: assert property (
    run_q && new_clk_tick && tick_q == 4'h9 |-> ##[1:4] $changed(sys_clk_sel))
    else $error("changeover missing");
  monitor_rc_a: assert property (
    !monitor_cfg_n && !switch_cfg_n && periph_clk_en && $past(rst_n) |-> ##[0:3] osc_enable[5])
    else $error("low-power rc off");
  sleep_halt_a: assert property (!periph_clk_en |-> cpu_halt && $stable(sys_clk_sel))
    else $error("sleep state wrong");
  wake_up_a: assert property (cpu_halt && (wake_irq || wdt_timeout) |-> ##[1:4] !cpu_halt)
    else $error("no wake");
  wdt_clear_a: assert property (
    pwr_save_req && wdt_enabled && !cpu_halt |-> ##[0:3] wdt_clear)
    else $error("watchdog not cleared");
endmodule

bind csw_clock_manager csw_clock_manager_chk chk_u (.clk, .rst_n, .psel, .penable, .pready,
  .switch_cfg_n, .monitor_cfg_n, .initial_source_config, .wdt_enabled, .new_clk_tick,
  .clock_failed, .pwr_save_req, .wake_irq, .wdt_timeout, .osc_enable, .sys_clk_sel,
  .clock_fail_trap, .wdt_clear, .cpu_halt, .periph_clk_en, .handover_start);

// File: tb.sv
// self-checking bench for the clock manager
`timescale 1ns/10ps
`include "csw_defs.svh"
module tb;
  localparam logic [11:0] CTL = `CSW_OFS_CONTROL;
  localparam logic [11:0] TRM = `CSW_OFS_TRIM;
  csw_pkg::csw_apb_req_t q;
  logic        clk, rst_n, switch_cfg_n, monitor_cfg_n, wdt_enabled, osc_ready_pin;
  logic        pll_lock_pin, new_clk_tick, clock_failed, pwr_save_req, pwr_save_sleep;
  logic        wake_irq, wdt_timeout, pready, pslverr, clock_fail_trap, wdt_clear;
  logic        cpu_halt, periph_clk_en, handover_start, err_seen;
  logic [2:0]  initial_source_config, sys_clk_sel;
  logic [5:0]  osc_enable, rc_trim_field;
  logic [31:0] prdata, rd_v;
  logic [2:0]  seq [8] = '{3'h1, 3'h0, 3'h3, 3'h0, 3'h2, 3'h4, 3'h5, 3'h0};
  int          error_cnt = 0, n_checks = 0, ho_cnt = 0, trap_cnt = 0, wc_cnt = 0;

  csw_clock_manager dut_u (.clk, .rst_n, .psel(q.psel), .penable(q.penable),
    .pwrite(q.pwrite), .paddr(q.paddr), .pwdata(q.pwdata), .prdata, .pready, .pslverr,
    .switch_cfg_n, .monitor_cfg_n, .initial_source_config, .wdt_enabled, .osc_ready_pin,
    .pll_lock_pin, .new_clk_tick, .clock_failed, .pwr_save_req, .pwr_save_sleep, .wake_irq,
    .wdt_timeout, .osc_enable, .sys_clk_sel, .rc_trim_field, .clock_fail_trap, .wdt_clear,
    .cpu_halt, .periph_clk_en, .handover_start);

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // event counters for pulses
  always @(posedge clk) begin
    if (handover_start === 1'b1) ho_cnt <= ho_cnt + 1;
    if (clock_fail_trap === 1'b1) trap_cnt <= trap_cnt + 1;
    if (wdt_clear === 1'b1) wc_cnt <= wc_cnt + 1;
  end

  task conclude;
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    q <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    q.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    chk("pready", pready, 1'b1);
    rd_v = prdata;
    err_seen = pslverr;
    q.psel <= 1'b0;
    q.penable <= 1'b0;
  endtask

  // unlock key pair then control write
  task ctl(input logic [2:0] t, input logic rq);
    apb(1'b1, `CSW_OFS_UNLOCK, `CSW_KEY_FIRST);
    apb(1'b1, `CSW_OFS_UNLOCK, `CSW_KEY_SECOND);
    apb(1'b1, CTL, {21'h0, t, 7'h0, rq});
  endtask

  task automatic waitc(ref int c, input int c0);
    int n;
    n = 0;
    while (c == c0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("event count", c - c0, 1);
  endtask

  task ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      new_clk_tick <= 1'b1;
      @(posedge clk);
      new_clk_tick <= 1'b0;
      cyc($urandom % 3);
    end
  endtask

  function logic [2:0] fb(input logic [2:0] s);
    return (s == 3'h3) ? 3'h1 : 3'h0;
  endfunction

  // full switch to source t with start-up wait and ten ticks
  task sw(input logic [2:0] t);
    logic [2:0] o;
    int         h;
    o = sys_clk_sel;
    h = ho_cnt;
    osc_ready_pin <= 1'b0;
    pll_lock_pin <= 1'b0;
    ctl(t, 1'b1);
    cyc(8);
    apb(1'b0, CTL, 32'h0);
    if (t != 3'h0 && t != 3'h5) chk("early handover", ho_cnt - h, 0);
    chk("cpu runs", cpu_halt, 0);
    chk("lock pending", rd_v[5], 0);
    osc_ready_pin <= 1'b1;
    pll_lock_pin <= 1'b1;
    waitc(ho_cnt, h);
    ticks(9);
    cyc(4);
    chk("source held", sys_clk_sel, o);
    ticks(1);
    cyc(4);
    chk("source new", sys_clk_sel, t);
    apb(1'b0, CTL, 32'h0);
    chk("control done", {rd_v[14:12], rd_v[0]}, {t, 1'b0});
    if (t[0] && t < 3'h4) chk("pll locked", rd_v[5], 1);
    chk("old source", osc_enable[o], o == 3'h5);
    chk("new source", osc_enable[t], 1);
  endtask

  initial begin
    cyc(30000);
    error_cnt++;
    conclude();
  end

  initial begin
    logic [2:0]  s;
    logic [5:0]  v;
    logic [31:0] d;
    int          h;
    void'($urandom(59000));
    q = '0;
    rst_n = 1'b0;
    switch_cfg_n = 1'b1;
    monitor_cfg_n = 1'b1;
    wdt_enabled = 1'b0;
    {osc_ready_pin, pll_lock_pin, new_clk_tick, clock_failed} = 4'h0;
    {pwr_save_req, pwr_save_sleep, wake_irq, wdt_timeout} = 4'h0;
    initial_source_config = 3'($urandom % 6);
    cyc(16);
    rst_n <= 1'b1;
    cyc(3);
    s = initial_source_config;
    chk("locked source", sys_clk_sel, s);
    apb(1'b0, CTL, 32'h0);
    chk("current field", rd_v[14:12], s);
    apb(1'b0, TRM, 32'h0);
    chk("trim reset", rd_v, 0);
    ctl((s == 3'h2) ? 3'h4 : 3'h2, 1'b1);
    cyc(8);
    apb(1'b0, CTL, 32'h0);
    chk("request held", rd_v[0], 0);
    chk("no handover", ho_cnt, 0);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped error", err_seen, 1);
    chk("unmapped data", rd_v, 0);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 6'h1f : (i == 1) ? 6'h20 : (i == 2) ? 6'h00 : 6'($urandom);
      d = $urandom;
      d[5:0] = v;
      apb(1'b1, TRM, d);
      apb(1'b0, TRM, 32'h0);
      chk("trim read", rd_v, {26'h0, v});
      chk("trim out", rc_trim_field, v);
    end
    switch_cfg_n <= 1'b0;
    monitor_cfg_n <= 1'b0;
    wdt_enabled <= 1'b1;
    rst_n <= 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    h = ho_cnt;
    ctl(3'h0, 1'b1);
    cyc(8);
    apb(1'b1, CTL, 32'h0000_0201);
    apb(1'b1, `CSW_OFS_UNLOCK, `CSW_KEY_FIRST);
    apb(1'b1, `CSW_OFS_UNLOCK, `CSW_KEY_SECOND);
    apb(1'b0, TRM, 32'h0);
    apb(1'b1, CTL, 32'h0000_0201);
    cyc(8);
    chk("ignored switch", ho_cnt - h, 0);
    apb(1'b0, CTL, 32'h0);
    chk("control kept", rd_v[14:0], 0);
    foreach (seq[i]) sw(seq[i]);
    for (int i = 0; i < 2; i++) begin
      s = 3'h2 + 3'(i);
      sw(s);
      h = trap_cnt;
      clock_failed <= 1'b1;
      waitc(trap_cnt, h);
      cyc(4);
      chk("fallback", sys_clk_sel, fb(s));
      apb(1'b0, CTL, 32'h0);
      chk("fail flag", rd_v[3], 1);
      clock_failed <= 1'b0;
      ctl(fb(s), 1'b0);
      apb(1'b0, CTL, 32'h0);
      chk("fail cleared", rd_v[3], 0);
    end
    for (int i = 0; i < 4; i++) begin
      s = sys_clk_sel;
      h = wc_cnt;
      pwr_save_sleep <= i[0];
      pwr_save_req <= 1'b1;
      cyc(1);
      pwr_save_req <= 1'b0;
      cyc(4);
      chk("halted", {cpu_halt, periph_clk_en}, {1'b1, !i[0]});
      chk("watchdog clear", wc_cnt - h, 1);
      if (i[0]) chk("sleep clocks", {osc_enable[s], osc_enable[5]}, 2'b01);
      wake_irq <= !i[1];
      wdt_timeout <= i[1];
      cyc(1);
      wake_irq <= 1'b0;
      wdt_timeout <= 1'b0;
      cyc(4);
      chk("awake", {cpu_halt, periph_clk_en}, 2'b01);
      chk("wake source", sys_clk_sel, s);
    end
    conclude();
  end
endmodule
